// file: design/uart_mode_pkg.sv
// constants shared by the serial channel mode-control block
package uart_mode_pkg;
  // register addresses on the plain register port
  localparam logic [1:0] ADDR_MODE = 2'h0;
  localparam logic [1:0] ADDR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_STAT = 2'h2;
  localparam logic [1:0] ADDR_DATA = 2'h3;
  // channel_mode_one fields
  localparam int M1_RX_RTS   = 7;
  localparam int M1_LEVEL_LO = 6;
  localparam int M1_ERR_BLK  = 5;
  localparam int M1_PAR_HI   = 4;
  localparam int M1_PAR_LO   = 3;
  localparam int M1_PAR_TYPE = 2;
  // channel_mode_two fields
  localparam int M2_MODE_HI  = 7;
  localparam int M2_MODE_LO  = 6;
  localparam int M2_TX_RTS   = 5;
  localparam int M2_CTS      = 4;
  localparam int M2_STOP_2X  = 3;
  // control register fields
  localparam int CTRL_TX_EN    = 0;
  localparam int CTRL_RX_EN    = 1;
  localparam int CTRL_RTS      = 2;
  localparam int CTRL_LEVEL_HI = 3;
  localparam int CTRL_RST_ERR  = 6;
  localparam int CTRL_SET_PTR  = 7;
  // status register fields
  localparam int ST_RX_RDY  = 0;
  localparam int ST_RX_LVL  = 1;
  localparam int ST_TX_RDY  = 2;
  localparam int ST_TX_EMT  = 3;
  localparam int ST_OVR     = 4;
  localparam int ST_PAR_ERR = 5;
  localparam int ST_FRM_ERR = 6;
  localparam int ST_BRK     = 7;
  // reset values
  localparam logic [7:0] MODE_ONE_RST = 8'h00;
  localparam logic [7:0] MODE_TWO_RST = 8'h00;
  // timing in 16x ticks, FIFO depth and receive fill levels
  localparam logic [5:0] TICKS_BIT  = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] STOP_BASE5 = 6'h11;
  localparam logic [5:0] STOP_BASE  = 6'h09;
  localparam logic [5:0] STOP_LONG  = 6'h19;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] LVL_1 = 4'h1;
  localparam logic [3:0] LVL_3 = 4'h3;
  localparam logic [3:0] LVL_6 = 4'h6;
  localparam logic [3:0] LVL_8 = 4'h8;

  typedef enum logic [1:0] {
    CH_NORMAL = 2'b00, CH_ECHO = 2'b01, CH_LOCAL = 2'b10, CH_REMOTE = 2'b11
  } chan_mode_t;
  typedef enum logic [1:0] {
    PAR_WITH = 2'b00, PAR_FORCE = 2'b01, PAR_NONE = 2'b10, PAR_MULTI = 2'b11
  } par_mode_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_START = 3'b001, S_DATA = 3'b010, S_PAR = 3'b011, S_STOP = 3'b100
  } ser_state_t;
endpackage : uart_mode_pkg

// file: design/uart_channel_mode_control.sv
// serial channel with mode registers, flow control, loopback and echo modes
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module uart_channel_mode_control #(
  parameter int DEPTH = uart_mode_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // register port
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  output logic      [7:0] o_rd_data,
  // bit clock enables from the rate generator
  input  wire logic       i_receive_tick16,
  input  wire logic       i_transmit_tick16,
  input  wire logic       i_transmit_ext_1x,
  // line pins
  input  wire logic       i_serial_in_pin,
  input  wire logic       i_clear_to_send_in_n,
  output logic            o_serial_out_pin,
  output logic            o_request_to_send_out_n
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [7:0]                 mode_one;
    logic [7:0]                 mode_two;
    logic                       ptr_two;
    logic                       tx_en;
    logic                       rx_en;
    logic                       rts_bit;
    logic                       level_hi;
    logic                       rx_s1;
    logic                       rx_s2;
    logic                       cts_s1;
    logic                       cts_s2;
    logic [DEPTH-1:0][10:0]     rx_mem;
    logic [AW-1:0]              rx_rd;
    logic [AW-1:0]              rx_wr;
    logic [AW:0]                rx_cnt;
    logic [DEPTH-1:0][7:0]      tx_mem;
    logic [AW-1:0]              tx_rd;
    logic [AW-1:0]              tx_wr;
    logic [AW:0]                tx_cnt;
    uart_mode_pkg::ser_state_t  rx_st;
    logic [5:0]                 rx_tk;
    logic [2:0]                 rx_bit;
    logic [7:0]                 rx_shift;
    logic                       rx_par;
    logic                       rx_blocked;
    logic                       brk_wait;
    logic                       overrun;
    logic                       rx_pend;
    logic [10:0]                rx_hold;
    logic [2:0]                 err_acc;
    logic                       echo_bit;
    logic [5:0]                 echo_hold;
    uart_mode_pkg::ser_state_t  tx_st;
    logic [5:0]                 tx_tk;
    logic [2:0]                 tx_bit;
    logic [7:0]                 tx_shift;
    logic                       tx_line;
    logic                       neg_arm;
    logic [5:0]                 neg_tk;
    logic [7:0]                 rd_data;
    logic                       ser_out;
    logic                       rts_n;
  } state_t;

  state_t q;
  state_t next_q;

  function automatic logic [7:0] len_mask(input logic [1:0] code);
    len_mask = 8'hFF >> (2'h3 - code);
  endfunction : len_mask

  // stop length in ticks; whole bits with a 1x clock
  function automatic logic [5:0] stop_len(input logic [3:0] f, input logic [1:0] code,
                                          input logic ext);
    logic [5:0] base;
    base = (code == 2'b00) ? uart_mode_pkg::STOP_BASE5 : uart_mode_pkg::STOP_BASE;
    if (f[3]) begin
      base = uart_mode_pkg::STOP_LONG;
    end
    if (ext) begin
      stop_len = f[3] ? 6'h02 : 6'h01;
    end else begin
      stop_len = base + {3'h0, f[2:0]};
    end
  endfunction : stop_len

  uart_mode_pkg::chan_mode_t cmode;
  uart_mode_pkg::par_mode_t  pmode;
  logic       rx_tick;
  logic       tx_tick;
  logic       rx_line;
  logic       par_on;
  logic [2:0] last_bit;
  logic [5:0] bit_len;
  logic       echo_on;
  logic [10:0] top;
  logic       rst_err;
  logic [7:0] status;
  logic       level_hit;

  always_comb begin
    // mode fields are used combinationally, so a change acts at once
    cmode    = uart_mode_pkg::chan_mode_t'(q.mode_two[uart_mode_pkg::M2_MODE_HI:
                                                      uart_mode_pkg::M2_MODE_LO]);
    pmode    = uart_mode_pkg::par_mode_t'(q.mode_one[uart_mode_pkg::M1_PAR_HI:
                                                     uart_mode_pkg::M1_PAR_LO]);
    par_on   = (pmode != uart_mode_pkg::PAR_NONE);
    last_bit = {1'b1, q.mode_one[1:0]};
    last_bit = last_bit - 3'h4 + 3'h4;
    last_bit = 3'h4 + {1'b0, q.mode_one[1:0]};
    // local loopback runs the receiver from the transmit clock
    rx_tick  = (cmode == uart_mode_pkg::CH_LOCAL) ? i_transmit_tick16 : i_receive_tick16;
    tx_tick  = i_transmit_tick16;
    rx_line  = (cmode == uart_mode_pkg::CH_LOCAL) ? q.tx_line : q.rx_s2;
    bit_len  = i_transmit_ext_1x ? 6'h01 : uart_mode_pkg::TICKS_BIT;
    // stop bit still being resent keeps the echo path alive
    echo_on  = (cmode == uart_mode_pkg::CH_ECHO) || (cmode == uart_mode_pkg::CH_REMOTE) ||
               ((q.echo_hold != 6'h00) && q.tx_en);
    top      = q.rx_mem[q.rx_rd];
    rst_err  = i_wr_en && (i_addr == uart_mode_pkg::ADDR_CTRL) &&
               i_wr_data[uart_mode_pkg::CTRL_RST_ERR];
    // fill level from the two selector bits
    case ({q.level_hi, q.mode_one[uart_mode_pkg::M1_LEVEL_LO]})
      2'b00:   level_hit = (q.rx_cnt >= (AW+1)'(uart_mode_pkg::LVL_1));
      2'b01:   level_hit = (q.rx_cnt >= (AW+1)'(uart_mode_pkg::LVL_3));
      2'b10:   level_hit = (q.rx_cnt >= (AW+1)'(uart_mode_pkg::LVL_6));
      default: level_hit = (q.rx_cnt == (AW+1)'(uart_mode_pkg::LVL_8));
    endcase
    status = 8'h00;
    status[uart_mode_pkg::ST_RX_RDY] = (q.rx_cnt != '0);
    status[uart_mode_pkg::ST_RX_LVL] = level_hit;
    // transmit status inactive in echo or with transmitter off
    status[uart_mode_pkg::ST_TX_RDY] = q.tx_en && !echo_on && (q.tx_cnt != FULL);
    status[uart_mode_pkg::ST_TX_EMT] = q.tx_en && !echo_on && (q.tx_cnt == '0) &&
                                       (q.tx_st == uart_mode_pkg::S_IDLE);
    status[uart_mode_pkg::ST_OVR] = q.overrun;
    if (q.mode_one[uart_mode_pkg::M1_ERR_BLK]) begin
      status[7:5] = q.err_acc;
    end else if (q.rx_cnt != '0) begin
      status[7:5] = top[10:8];
    end
    // error status inactive in remote loopback
    if (cmode == uart_mode_pkg::CH_REMOTE) begin
      status[7:4] = 4'h0;
    end
  end

  always_comb begin
    logic       push;
    logic       pop;
    logic       tpush;
    logic       tpop;
    logic       stop_ok;
    logic       par_bad;
    logic [7:0] tdata;
    logic [10:0] word;
    push    = 1'b0;
    word    = 11'h000;
    pop     = 1'b0;
    tpush   = 1'b0;
    tpop    = 1'b0;
    stop_ok = 1'b1;
    par_bad = 1'b0;
    tdata   = q.tx_mem[q.tx_rd] & len_mask(q.mode_one[1:0]);
    next_q  = q;
    next_q.rx_s1  = i_serial_in_pin;
    next_q.rx_s2  = q.rx_s1;
    next_q.cts_s1 = i_clear_to_send_in_n;
    next_q.cts_s2 = q.cts_s1;

    // register writes
    if (i_wr_en) begin
      case (i_addr)
        uart_mode_pkg::ADDR_MODE: begin
          // pointer steps from mode one to mode two and stays
          if (q.ptr_two) begin
            next_q.mode_two = i_wr_data;
          end else begin
            next_q.mode_one = i_wr_data;
            next_q.ptr_two  = 1'b1;
          end
        end
        uart_mode_pkg::ADDR_CTRL: begin
          next_q.tx_en    = i_wr_data[uart_mode_pkg::CTRL_TX_EN];
          next_q.rx_en    = i_wr_data[uart_mode_pkg::CTRL_RX_EN];
          next_q.rts_bit  = i_wr_data[uart_mode_pkg::CTRL_RTS];
          next_q.level_hi = i_wr_data[uart_mode_pkg::CTRL_LEVEL_HI];
          if (i_wr_data[uart_mode_pkg::CTRL_SET_PTR]) begin
            next_q.ptr_two = 1'b0;
          end
        end
        // host writes to the transmitter are blocked during echo
        uart_mode_pkg::ADDR_DATA: tpush = q.tx_en && !echo_on && (q.tx_cnt != FULL);
        default: ;
      endcase
    end

    // register reads, data stands in the following cycle
    if (i_rd_en) begin
      case (i_addr)
        uart_mode_pkg::ADDR_MODE: begin
          next_q.rd_data = q.ptr_two ? q.mode_two : q.mode_one;
          next_q.ptr_two = 1'b1;
        end
        uart_mode_pkg::ADDR_CTRL: next_q.rd_data = {4'h0, q.level_hi, q.rts_bit,
                                                    q.rx_en, q.tx_en};
        uart_mode_pkg::ADDR_STAT: next_q.rd_data = status;
        default: begin
          next_q.rd_data = (q.rx_cnt != '0) ? top[7:0] : 8'h00;
          pop = (q.rx_cnt != '0);
        end
      endcase
    end

    // receiver, 16x oversampled
    if (rx_tick && q.rx_en) begin
      next_q.rx_tk = q.rx_tk + 6'h01;
      case (q.rx_st)
        uart_mode_pkg::S_IDLE: begin
          next_q.echo_bit = rx_line;
          next_q.rx_tk    = 6'h00;
          if (q.brk_wait) begin
            next_q.brk_wait = !rx_line;
          end else if (!rx_line) begin
            next_q.rx_st = uart_mode_pkg::S_START;
          end
        end
        uart_mode_pkg::S_START: begin
          if (q.rx_tk == uart_mode_pkg::TICKS_HALF - 6'h01) begin
            next_q.rx_tk    = 6'h00;
            next_q.rx_bit   = 3'h0;
            next_q.rx_shift = 8'h00;
            next_q.rx_st    = rx_line ? uart_mode_pkg::S_IDLE : uart_mode_pkg::S_DATA;
            next_q.echo_bit = rx_line;
            // ninth byte starting while full negates request-to-send
            if (!rx_line && q.mode_one[uart_mode_pkg::M1_RX_RTS] && (q.rx_cnt == FULL)) begin
              next_q.rx_blocked = 1'b1;
            end
          end
        end
        uart_mode_pkg::S_DATA: begin
          if (q.rx_tk == uart_mode_pkg::TICKS_BIT - 6'h01) begin
            next_q.rx_tk            = 6'h00;
            next_q.rx_shift[q.rx_bit] = rx_line;
            next_q.echo_bit         = rx_line;
            next_q.rx_bit           = q.rx_bit + 3'h1;
            if (q.rx_bit == last_bit) begin
              next_q.rx_st = par_on ? uart_mode_pkg::S_PAR : uart_mode_pkg::S_STOP;
            end
          end
        end
        uart_mode_pkg::S_PAR: begin
          if (q.rx_tk == uart_mode_pkg::TICKS_BIT - 6'h01) begin
            next_q.rx_tk    = 6'h00;
            next_q.rx_par   = rx_line;
            next_q.echo_bit = rx_line;
            next_q.rx_st    = uart_mode_pkg::S_STOP;
          end
        end
        default: begin
          // only the centre of the first stop bit is checked
          if (q.rx_tk == uart_mode_pkg::TICKS_BIT - 6'h01) begin
            stop_ok         = rx_line;
            next_q.echo_bit = rx_line;
            next_q.rx_st    = uart_mode_pkg::S_IDLE;
            // receive parity check; multidrop keeps the address/data bit
            case (pmode)
              uart_mode_pkg::PAR_WITH:  par_bad = (^q.rx_shift) ^
                                                  q.mode_one[uart_mode_pkg::M1_PAR_TYPE] ^
                                                  q.rx_par;
              uart_mode_pkg::PAR_FORCE: par_bad = q.rx_par ^
                                                  q.mode_one[uart_mode_pkg::M1_PAR_TYPE];
              uart_mode_pkg::PAR_MULTI: par_bad = q.rx_par;
              default:                  par_bad = 1'b0;
            endcase
            // the whole stop bit is resent after the sample
            if (echo_on) begin
              next_q.echo_hold = uart_mode_pkg::TICKS_BIT;
            end
            next_q.brk_wait = !rx_line && (q.rx_shift == 8'h00) && !(par_on && q.rx_par);
            // remote loopback keeps data from the host
            if (cmode != uart_mode_pkg::CH_REMOTE) begin
              push = 1'b1;
            end
          end
        end
      endcase
      if (q.echo_hold != 6'h00) begin
        next_q.echo_hold = q.echo_hold - 6'h01;
      end
    end

    // a ninth character waits in the hold stage until a slot frees; one more
    // completing while it still waits is lost as overrun, and the set beats reset-error
    word = {next_q.brk_wait, !stop_ok, par_bad, q.rx_shift};
    if (rst_err) begin
      next_q.overrun = 1'b0;
    end
    if (push && q.rx_pend) begin
      push           = 1'b0;
      next_q.overrun = 1'b1;
    end else if (push && (q.rx_cnt == FULL) && !pop) begin
      push           = 1'b0;
      next_q.rx_pend = 1'b1;
      next_q.rx_hold = word;
    end
    if (q.rx_pend && !push && ((q.rx_cnt != FULL) || pop)) begin
      push           = 1'b1;
      word           = q.rx_hold;
      next_q.rx_pend = 1'b0;
    end
    if (push) begin
      next_q.rx_mem[q.rx_wr] = word;
      next_q.rx_wr = q.rx_wr + AW'(1);
    end
    if (pop) begin
      next_q.rx_rd = q.rx_rd + AW'(1);
    end
    next_q.rx_cnt = q.rx_cnt + (AW+1)'(push) - (AW+1)'(pop);
    // request-to-send comes back once a slot frees
    if (next_q.rx_cnt != FULL) begin
      next_q.rx_blocked = 1'b0;
    end
    // accumulate top-of-FIFO errors; a new top wins over reset-error
    next_q.err_acc = (rst_err ? 3'h0 : q.err_acc) | ((q.rx_cnt != '0) ? top[10:8] : 3'h0);

    // transmitter; drains the FIFO even with the transmitter disabled
    if (tpush) begin
      next_q.tx_mem[q.tx_wr] = i_wr_data;
      next_q.tx_wr = q.tx_wr + AW'(1);
    end
    case (q.tx_st)
      uart_mode_pkg::S_IDLE: begin
        next_q.tx_line = 1'b1;
        // clear-to-send looked at only before a character
        if ((q.tx_cnt != '0) && !(q.mode_two[uart_mode_pkg::M2_CTS] && q.cts_s2)) begin
          tpop            = 1'b1;
          next_q.tx_shift = tdata;
          next_q.tx_st    = uart_mode_pkg::S_START;
          next_q.tx_tk    = 6'h00;
          next_q.tx_line  = 1'b0;
          next_q.neg_tk   = 6'h00;
        end
      end
      default: begin
        if (tx_tick) begin
          next_q.tx_tk = q.tx_tk + 6'h01;
          if ((q.tx_st != uart_mode_pkg::S_STOP) && (q.tx_tk == bit_len - 6'h01)) begin
            next_q.tx_tk = 6'h00;
            case (q.tx_st)
              uart_mode_pkg::S_START: begin
                next_q.tx_st   = uart_mode_pkg::S_DATA;
                next_q.tx_line = q.tx_shift[0];
                next_q.tx_bit  = 3'h0;
              end
              uart_mode_pkg::S_DATA: begin
                next_q.tx_bit  = q.tx_bit + 3'h1;
                next_q.tx_line = q.tx_shift[q.tx_bit + 3'h1];
                if (q.tx_bit == last_bit) begin
                  // parity appended per parity mode and type
                  next_q.tx_st   = par_on ? uart_mode_pkg::S_PAR : uart_mode_pkg::S_STOP;
                  next_q.tx_line = !par_on ||
                                   (q.mode_one[uart_mode_pkg::M1_PAR_TYPE] ^
                                    ((pmode == uart_mode_pkg::PAR_WITH) & (^q.tx_shift)));
                end
              end
              default: begin
                next_q.tx_st   = uart_mode_pkg::S_STOP;
                next_q.tx_line = 1'b1;
              end
            endcase
          end else if ((q.tx_st == uart_mode_pkg::S_STOP) &&
                       (q.tx_tk == stop_len(q.mode_two[3:0], q.mode_one[1:0],
                                            i_transmit_ext_1x) - 6'h01)) begin
            next_q.tx_st   = uart_mode_pkg::S_IDLE;
            next_q.neg_arm = 1'b1;
            next_q.neg_tk  = 6'h00;
          end
        end
      end
    endcase
    if (tpop) begin
      next_q.tx_rd = q.tx_rd + AW'(1);
    end
    next_q.tx_cnt = q.tx_cnt + (AW+1)'(tpush) - (AW+1)'(tpop);

    // auto-negate one bit time after the line has gone idle
    if (q.mode_two[uart_mode_pkg::M2_TX_RTS] && q.neg_arm && !tpop &&
        (q.tx_st == uart_mode_pkg::S_IDLE) && (q.tx_cnt == '0) && tx_tick) begin
      next_q.neg_tk = q.neg_tk + 6'h01;
      if (q.neg_tk == bit_len - 6'h01) begin
        next_q.neg_arm = 1'b0;
        if (!(i_wr_en && (i_addr == uart_mode_pkg::ADDR_CTRL))) begin
          next_q.rts_bit = 1'b0;
        end
      end
    end

    case (cmode)
      uart_mode_pkg::CH_LOCAL: next_q.ser_out = 1'b1;
      default:                 next_q.ser_out = echo_on ? q.echo_bit : q.tx_line;
    endcase
    // output is the port bit unless the receiver is holding it off
    next_q.rts_n = !q.rts_bit || q.rx_blocked;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q          <= '0;
      q.mode_one <= uart_mode_pkg::MODE_ONE_RST;
      q.mode_two <= uart_mode_pkg::MODE_TWO_RST;
      q.rx_s1    <= 1'b1;
      q.rx_s2    <= 1'b1;
      q.cts_s1   <= 1'b1;
      q.cts_s2   <= 1'b1;
      q.echo_bit <= 1'b1;
      q.tx_line  <= 1'b1;
      q.ser_out  <= 1'b1;
      q.rts_n    <= 1'b1;
    end else if (i_ce) begin
      q <= next_q;
    end
  end

  assign o_rd_data               = q.rd_data;
  assign o_serial_out_pin        = q.ser_out;
  assign o_request_to_send_out_n = q.rts_n;
endmodule : uart_channel_mode_control

// file: bench/uart_mode_sva.sv
// concurrent checks on the register port and line pins of the serial channel
`timescale 1ns/1ps
module uart_mode_sva (
  // clock, reset, enable
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_ce,
  // register port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_wr_en,
  input wire logic       i_rd_en,
  input wire logic [7:0] o_rd_data,
  // line pins
  input wire logic       o_serial_out_pin,
  input wire logic       o_request_to_send_out_n
);
  logic       ptr, p_q, rd_q;
  logic [1:0] a_q;
  logic [7:0] m1, m2;
  logic [3:0] ctl;
  wire        mw = i_wr_en && i_addr == 2'h0;
  // shadow pointer and registers, rebuilt from port traffic only
  always_ff @(posedge i_core_clk) begin
    rd_q <= i_ce && i_rd_en && !i_rst;
    a_q <= i_addr;
    p_q <= ptr;
    if (i_rst) begin
      ptr <= 1'b0;
      m1 <= uart_mode_pkg::MODE_ONE_RST;
      m2 <= uart_mode_pkg::MODE_TWO_RST;
      ctl <= 4'h0;
    end else if (i_ce) begin
      if (mw && !ptr) m1 <= i_wr_data;
      if (mw && ptr) m2 <= i_wr_data;
      if ((i_wr_en || i_rd_en) && i_addr == 2'h0) ptr <= 1'b1;
      if (i_wr_en && i_addr == 2'h1) begin
        ctl <= i_wr_data[3:0];
        ptr <= ptr && !i_wr_data[7];
      end
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_reset_idle: assert property (
    $past(i_rst) |-> o_serial_out_pin && o_request_to_send_out_n && o_rd_data == 8'h00)
    else $error("outputs not idle after reset");
  a_ce_freeze: assert property (!$past(i_ce) |-> $stable(o_serial_out_pin)
    && $stable(o_request_to_send_out_n) && $stable(o_rd_data))
    else $error("outputs moved while enable low");
  a_mode_one_read: assert property (
    rd_q && a_q == 2'h0 && !p_q |-> o_rd_data == m1) else $error("mode one readback");
  a_mode_two_read: assert property (
    rd_q && a_q == 2'h0 && p_q |-> o_rd_data == m2) else $error("mode two readback");
  a_local_high: assert property (
    m2[7:6] == 2'b10 && $stable(m2) |-> o_serial_out_pin) else $error("line low in loopback");
  a_echo_status: assert property (
    rd_q && a_q == 2'h2 && m2[7:6] == 2'b01 |-> o_rd_data[3:2] == 2'b00)
    else $error("transmit status shown in echo");
  a_txoff_status: assert property (
    rd_q && a_q == 2'h2 && !ctl[0] |-> o_rd_data[3:2] == 2'b00)
    else $error("transmit status shown while disabled");
  a_rts_port: assert property (
    !ctl[2] && $stable(ctl) |-> o_request_to_send_out_n) else $error("rts asserted, bit clear");
endmodule : uart_mode_sva
bind uart_channel_mode_control uart_mode_sva i_uart_mode_sva (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
  .o_serial_out_pin(o_serial_out_pin), .o_request_to_send_out_n(o_request_to_send_out_n));

// file: bench/serial_peer.sv
// remote serial device on the channel's line pins
`timescale 1ns/1ps
module serial_peer (
  // clock and bit tick
  input  wire logic i_clk,
  input  wire logic i_tick,
  // line pins
  input  wire logic i_line,
  input  wire logic i_rts_n,
  output logic      o_line
);
  initial o_line = 1'b1;
  task automatic ticks(input int n);
    repeat (n) @(posedge i_clk iff i_tick);
  endtask : ticks
  task automatic send(input logic [7:0] d);
    // start only while request-to-send is asserted
    wait (i_rts_n === 1'b0);
    ticks(1);
    o_line <= 1'b0;
    for (int i = 0; i <= 8; i++) begin
      ticks(16);
      o_line <= (i < 8) ? d[i] : 1'b1;
    end
    ticks(16);
  endtask : send
  task automatic recv(output logic [7:0] d, input int nb);
    d = 8'h00;
    @(posedge i_clk iff i_line === 1'b0);
    ticks(8);
    for (int i = 0; i < nb; i++) begin
      ticks(16);
      d[i] = i_line;
    end
    ticks(16);
  endtask : recv
endmodule : serial_peer

// file: bench/tb_top.sv
// register-level regression of the serial channel mode-control block
`timescale 1ns/1ps
module tb_top;
  logic       clk, rst, ce, we, re, tk, cts_n, sin, sout, rts_n;
  logic [1:0] addr;
  logic [7:0] wd, rdat, got;
  int         n_fail = 0, comparisons = 0, cyc = 0;
  uart_channel_mode_control i_uart_channel_mode_control (
    .i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_addr(addr), .i_wr_data(wd),
    .i_wr_en(we), .i_rd_en(re), .o_rd_data(rdat), .i_receive_tick16(tk),
    .i_transmit_tick16(tk), .i_transmit_ext_1x(1'b0), .i_serial_in_pin(sin),
    .i_clear_to_send_in_n(cts_n), .o_serial_out_pin(sout), .o_request_to_send_out_n(rts_n));
  serial_peer peer (.i_clk(clk), .i_tick(tk), .i_line(sout), .i_rts_n(rts_n), .o_line(sin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // bit ticks every other cycle keep characters short; the ceiling cuts hangs
  always @(posedge clk) begin
    tk <= rst ? 1'b0 : ~tk;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic peek(input logic [1:0] a);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
  endtask : peek
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    peek(a);
    chk(rdat & m, e);
  endtask : rd
  task automatic mode(input logic [7:0] m1, input logic [7:0] m2);
    wr(2'h1, 8'h8F);
    wr(2'h0, m1);
    wr(2'h0, m2);
  endtask : mode
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    {rst, ce, cts_n, we, re, addr, wd} = 15'h6000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(2'h0, 8'h00, 8'hFF);
    rd(2'h0, 8'h00, 8'hFF);
    mode(8'hD3, 8'h07);
    wr(2'h1, 8'h8F);
    rd(2'h0, 8'hD3, 8'hFF);
    rd(2'h0, 8'h07, 8'hFF);
    rd(2'h0, 8'h07, 8'hFF);
    $display("pointer done");
    for (int l = 0; l < 4; l++) begin
      mode(8'hD0 + 8'(l), 8'h07);
      fork
        wr(2'h3, 8'hA5);
        peer.recv(got, 5 + l);
      join
      chk(got, 8'hA5 & (8'hFF >> (3 - l)));
    end
    $display("lengths done");
    for (int k = 0; k < 8; k++) begin
      rd(2'h2, 8'h00, 8'h02);
      peer.send(8'h10 + 8'(k));
    end
    rd(2'h2, 8'h03, 8'h03);
    peer.send(8'h18);
    chk({7'h00, rts_n}, 8'h01);
    for (int k = 0; k < 9; k++) rd(2'h3, 8'h10 + 8'(k), 8'hFF);
    rd(2'h2, 8'h00, 8'h01);
    chk({7'h00, rts_n}, 8'h00);
    $display("flow control done");
    mode(8'hD3, 8'h87);
    wr(2'h3, 8'h3C);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    for (int t = 0; t < 300 && rdat[0] !== 1'b1; t++) peek(2'h2);
    rd(2'h3, 8'h3C, 8'hFF);
    $display("loopback done");
    mode(8'hD3, 8'h47);
    fork
      peer.send(8'h5A);
      peer.recv(got, 8);
    join
    chk(got, 8'h5A);
    rd(2'h2, 8'h00, 8'h0C);
    $display("echo done");
    // the echoed stop bit still goes out for a bit time and refuses host data meanwhile
    repeat (40) @(posedge clk);
    cts_n <= 1'b1;
    mode(8'hD3, 8'h17);
    wr(2'h3, 8'h77);
    repeat (400) @(posedge clk);
    rd(2'h2, 8'h00, 8'h08);
    @(posedge clk);
    cts_n <= 1'b0;
    peer.recv(got, 8);
    chk(got, 8'h77);
    wr(2'h1, 8'h0E);
    rd(2'h2, 8'h00, 8'h0C);
    $display("clear to send done");
    mode(8'hD3, 8'h27);
    fork
      wr(2'h3, 8'h55);
      peer.recv(got, 8);
    join
    chk(got, 8'h55);
    chk({7'h00, rts_n}, 8'h00);
    repeat (100) @(posedge clk);
    chk({7'h00, rts_n}, 8'h01);
    rd(2'h1, 8'h0B, 8'h0F);
    $display("auto negate done");
    results();
  end
endmodule : tb_top
